/* File: rtl/thermal_sensor_register_map.sv */
// Register bank of a two-channel temperature sensor behind a command-byte index.
`timescale 1ns/1ps
module thermal_sensor_register_map #(
   parameter int CONV_LEN = thermal_regs_pkg::CONV_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_command_valid,
   input wire logic [7:0] i_register_index_bits,
   input wire logic i_write_valid,
   input wire logic [7:0] i_write_data,
   input wire logic i_read_request,
   output logic o_read_valid,
   output logic [7:0] o_read_data,
   input wire logic [10:0] i_local_temp,
   input wire logic [12:0] i_remote_temp_signed,
   input wire logic [12:0] i_remote_temp_unsigned,
   input wire logic i_diode_fault,
   input wire logic i_not_ready,
   output logic o_conversion_start,
   output logic o_critical_alarm_n,
   output logic o_overtemp_alarm_n,
   output logic [4:0] o_general_config,
   output logic [4:0] o_diode_config,
   output logic [1:0] o_conversion_rate,
   output logic [10:0] o_remote_offset
);
   import thermal_regs_pkg::*;

   logic [7:0] index_q;
   logic [4:0] config_q;
   logic [1:0] rate_q;
   logic [7:0] ros_limit_q;
   logic [7:0] rcrit_limit_q;
   logic [6:0] local_limit_q;
   logic [4:0] hyst_q;
   logic [4:0] diode_cfg_q;
   logic [7:0] offset_hi_q;
   logic [2:0] offset_lo_q;
   logic [10:0] local_q;
   logic [12:0] remote_s_q;
   logic [12:0] remote_u_q;
   logic fault_q;
   logic not_ready_q;
   logic los_q, lcrit_q, ros_q, rcrit_q;
   logic crit_alarm_q, overtemp_alarm_q;
   conv_state_t conv_q;
   logic [15:0] conv_cnt_q;
   logic start_q;
   logic read_valid_q;
   logic [7:0] read_data_q;
   logic [7:0] rd_byte;
   logic [7:0] local_frac_byte, remote_sfrac_byte, remote_ufrac_byte;
   logic do_read, do_write, conv_end, one_shot;

   // Above limit or still inside the hysteresis band
   function automatic logic hold_alarm(input logic [7:0] temp, input logic [7:0] limit,
                                       input logic [4:0] hyst, input logic active);
      logic [8:0] low;
      low = {1'b0, limit} - {4'h0, hyst};
      if (temp > limit) begin
         hold_alarm = 1'b1;
      end else if (active && (low[8] || ({1'b0, temp} >= low))) begin
         hold_alarm = 1'b1;
      end else begin
         hold_alarm = 1'b0;
      end
   endfunction

   assign do_read = i_read_request;
   assign do_write = i_write_valid;
   assign conv_end = (conv_q == conv_busy_t) && (conv_cnt_q == 16'h0000);
   assign one_shot = do_write && (index_q == IDX_ONE_SHOT) && config_q[CFG_HALT];

   // Index follows each command byte and holds otherwise
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         index_q <= IDX_RESET;
      end else if (i_command_valid) begin
         index_q <= i_register_index_bits;
      end
   end

   // Writable registers; read-only and one-shot indices fall through untouched
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         config_q <= RST_CONFIG;
         rate_q <= RST_RATE;
         ros_limit_q <= RST_ROS_LIMIT;
         rcrit_limit_q <= RST_RCRIT_LIMIT;
         local_limit_q <= RST_LOCAL_LIMIT;
         hyst_q <= RST_HYST;
         diode_cfg_q <= RST_DIODE_CFG;
         offset_hi_q <= RST_OFFSET_HI;
         offset_lo_q <= RST_OFFSET_LO;
      end else if (do_write) begin
         unique case (index_q)
            IDX_CONFIG_A, IDX_CONFIG_B: begin
               config_q <= i_write_data[4:0];
            end
            IDX_RATE_A, IDX_RATE_B: begin
               rate_q <= i_write_data[1:0];
            end
            IDX_ROS_LIMIT_A, IDX_ROS_LIMIT_B: begin
               ros_limit_q <= i_write_data;
            end
            IDX_RCRIT_LIMIT: begin
               rcrit_limit_q <= i_write_data;
            end
            IDX_LOCAL_LIMIT: begin
               local_limit_q <= i_write_data[6:0];
            end
            IDX_HYST: begin
               hyst_q <= i_write_data[4:0];
            end
            IDX_DIODE_CFG: begin
               diode_cfg_q <= i_write_data[4:0];
            end
            IDX_OFFSET_HI: begin
               offset_hi_q <= i_write_data;
            end
            IDX_OFFSET_LO: begin
               offset_lo_q <= i_write_data[7:5];
            end
            default: begin
               // Read-only indices and one-shot data are dropped
               config_q <= config_q;
            end
         endcase
      end
   end

   // Conversion sequencer: runs free when running, one pass per one-shot taken in idle when halted
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         conv_q <= conv_idle_t;
         conv_cnt_q <= 16'h0000;
         start_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         unique case (conv_q)
            conv_idle_t: begin
               if (!config_q[CFG_HALT] || one_shot) begin
                  conv_q <= conv_busy_t;
                  conv_cnt_q <= 16'(CONV_LEN - 1);
                  start_q <= 1'b1;
               end
            end
            conv_busy_t: begin
               if (conv_end) begin
                  conv_q <= conv_done_t;
               end else begin
                  conv_cnt_q <= conv_cnt_q - 16'h0001;
               end
            end
            conv_done_t: begin
               conv_q <= conv_idle_t;
            end
         endcase
      end
   end

   // Capture results and compare against limits at the end of each conversion
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         local_q <= '0;
         remote_s_q <= '0;
         remote_u_q <= '0;
         fault_q <= 1'b0;
         not_ready_q <= 1'b0;
         los_q <= 1'b0;
         lcrit_q <= 1'b0;
         ros_q <= 1'b0;
         rcrit_q <= 1'b0;
      end else begin
         not_ready_q <= i_not_ready;
         if (conv_end) begin
            local_q <= i_local_temp;
            remote_s_q <= i_remote_temp_signed;
            remote_u_q <= i_remote_temp_unsigned;
            fault_q <= i_diode_fault;
            los_q <= hold_alarm({1'b0, i_local_temp[9:3]}, {1'b0, local_limit_q}, hyst_q, los_q)
                     && !i_local_temp[10];
            lcrit_q <= hold_alarm({1'b0, i_local_temp[9:3]}, {1'b0, local_limit_q}, hyst_q, lcrit_q)
                       && !i_local_temp[10];
            ros_q <= hold_alarm(i_remote_temp_unsigned[12:5], ros_limit_q, hyst_q, ros_q);
            rcrit_q <= hold_alarm(i_remote_temp_unsigned[12:5], rcrit_limit_q, hyst_q, rcrit_q);
         end
      end
   end

   // Pins are active low and clear only when every unmasked source has cleared
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         crit_alarm_q <= 1'b1;
         overtemp_alarm_q <= 1'b1;
      end else begin
         crit_alarm_q <= !((rcrit_q && !config_q[CFG_MASK_RCRIT]) ||
                           (lcrit_q && !config_q[CFG_MASK_LCRIT]) ||
                           (fault_q && !diode_cfg_q[DC_FAULT_MASK]));
         overtemp_alarm_q <= !((ros_q && !config_q[CFG_MASK_ROS]) ||
                               (los_q && !config_q[CFG_MASK_LOS]));
      end
   end

   // Fraction bytes freeze on their integer read so both halves match
   fraction_latch #(.WIDTH(LOCAL_FRAC_W)) u_local_frac (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_live(local_q[2:0]),
      .i_freeze(do_read && (index_q == IDX_LOCAL_INT)),
      .i_release(do_read && (index_q == IDX_LOCAL_FRAC)),
      .o_byte(local_frac_byte)
   );
   fraction_latch #(.WIDTH(REMOTE_FRAC_W)) u_remote_sfrac (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_live(remote_s_q[4:0]),
      .i_freeze(do_read && (index_q == IDX_REMOTE_SINT)),
      .i_release(do_read && (index_q == IDX_REMOTE_SFRAC)),
      .o_byte(remote_sfrac_byte)
   );
   fraction_latch #(.WIDTH(REMOTE_FRAC_W)) u_remote_ufrac (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_live(remote_u_q[4:0]),
      .i_freeze(do_read && (index_q == IDX_REMOTE_UINT)),
      .i_release(do_read && (index_q == IDX_REMOTE_UFRAC)),
      .o_byte(remote_ufrac_byte)
   );

   // Read multiplexer; unmapped and write-only indices read zero
   always_comb begin
      rd_byte = 8'h00;
      unique case (index_q)
         IDX_LOCAL_INT: rd_byte = local_q[10:3];
         IDX_REMOTE_SINT: rd_byte = remote_s_q[12:5];
         IDX_STATUS1: begin
            rd_byte = {3'h0, (conv_q != conv_idle_t), ros_q, rcrit_q, fault_q, (los_q | lcrit_q)};
         end
         IDX_CONFIG_A, IDX_CONFIG_B: rd_byte = {3'h0, config_q};
         IDX_RATE_A, IDX_RATE_B: rd_byte = {6'h00, rate_q};
         IDX_ROS_LIMIT_A, IDX_ROS_LIMIT_B: rd_byte = ros_limit_q;
         IDX_ONE_SHOT: rd_byte = 8'h00;
         IDX_REMOTE_SFRAC: rd_byte = remote_sfrac_byte;
         IDX_OFFSET_HI: rd_byte = offset_hi_q;
         IDX_OFFSET_LO: rd_byte = {offset_lo_q, 5'h00};
         IDX_RCRIT_LIMIT: rd_byte = rcrit_limit_q;
         IDX_LOCAL_LIMIT: rd_byte = {1'b0, local_limit_q};
         IDX_HYST: rd_byte = {3'h0, hyst_q};
         IDX_LOCAL_FRAC: rd_byte = local_frac_byte;
         IDX_REMOTE_UINT: rd_byte = remote_u_q[12:5];
         IDX_REMOTE_UFRAC: rd_byte = remote_ufrac_byte;
         IDX_STATUS2: rd_byte = {6'h00, not_ready_q, 1'b0};
         IDX_DIODE_CFG: rd_byte = {3'h0, diode_cfg_q};
         default: rd_byte = 8'h00;
      endcase
   end

   // Registered read answer, one cycle after the request
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         read_valid_q <= 1'b0;
         read_data_q <= 8'h00;
      end else begin
         read_valid_q <= do_read;
         if (do_read) begin
            read_data_q <= rd_byte;
         end
      end
   end

   assign o_read_valid = read_valid_q;
   assign o_read_data = read_data_q;
   assign o_conversion_start = start_q;
   assign o_critical_alarm_n = crit_alarm_q;
   assign o_overtemp_alarm_n = overtemp_alarm_q;
   assign o_general_config = config_q;
   assign o_diode_config = diode_cfg_q;
   assign o_conversion_rate = rate_q;
   assign o_remote_offset = {offset_hi_q, offset_lo_q};
endmodule // thermal_sensor_register_map

/* File: rtl/thermal_regs_pkg.sv */
// Register indices, field layouts, reset values and widths of the sensor register bank.
package thermal_regs_pkg;
   localparam logic [7:0] IDX_LOCAL_INT = 8'h00;
   localparam logic [7:0] IDX_REMOTE_SINT = 8'h01;
   localparam logic [7:0] IDX_STATUS1 = 8'h02;
   localparam logic [7:0] IDX_CONFIG_A = 8'h03;
   localparam logic [7:0] IDX_CONFIG_B = 8'h09;
   localparam logic [7:0] IDX_RATE_A = 8'h04;
   localparam logic [7:0] IDX_RATE_B = 8'h0a;
   localparam logic [7:0] IDX_ROS_LIMIT_A = 8'h07;
   localparam logic [7:0] IDX_ROS_LIMIT_B = 8'h0d;
   localparam logic [7:0] IDX_ONE_SHOT = 8'h0f;
   localparam logic [7:0] IDX_REMOTE_SFRAC = 8'h10;
   localparam logic [7:0] IDX_OFFSET_HI = 8'h11;
   localparam logic [7:0] IDX_OFFSET_LO = 8'h12;
   localparam logic [7:0] IDX_RCRIT_LIMIT = 8'h19;
   localparam logic [7:0] IDX_LOCAL_LIMIT = 8'h20;
   localparam logic [7:0] IDX_HYST = 8'h21;
   localparam logic [7:0] IDX_LOCAL_FRAC = 8'h30;
   localparam logic [7:0] IDX_REMOTE_UINT = 8'h31;
   localparam logic [7:0] IDX_REMOTE_UFRAC = 8'h32;
   localparam logic [7:0] IDX_STATUS2 = 8'h33;
   localparam logic [7:0] IDX_DIODE_CFG = 8'hbf;
   localparam logic [7:0] IDX_RESET = 8'h00;
   // Reset values
   localparam logic [4:0] RST_CONFIG = 5'h00;
   localparam logic [1:0] RST_RATE = 2'h2;
   localparam logic [7:0] RST_ROS_LIMIT = 8'h55;
   localparam logic [7:0] RST_RCRIT_LIMIT = 8'h6e;
   localparam logic [6:0] RST_LOCAL_LIMIT = 7'h55;
   localparam logic [4:0] RST_HYST = 5'h0a;
   localparam logic [4:0] RST_DIODE_CFG = 5'h1f;
   localparam logic [7:0] RST_OFFSET_HI = 8'h00;
   localparam logic [2:0] RST_OFFSET_LO = 3'h0;
   // General configuration fields
   localparam int CFG_HALT = 4;
   localparam int CFG_MASK_RCRIT = 3;
   localparam int CFG_MASK_ROS = 2;
   localparam int CFG_MASK_LCRIT = 1;
   localparam int CFG_MASK_LOS = 0;
   // Primary status fields
   localparam int ST_BUSY = 4;
   localparam int ST_ROS = 3;
   localparam int ST_RCRIT = 2;
   localparam int ST_FAULT = 1;
   localparam int ST_LOCAL = 0;
   // Diode configuration fields
   localparam int DC_FAULT_MASK = 2;
   // Fraction field widths, data left justified in the byte
   localparam int LOCAL_FRAC_W = 3;
   localparam int REMOTE_FRAC_W = 5;
   // Conversion time in ns and its cycle count at 50 MHz
   localparam int CLOCK_NS = 20;
   localparam int CONV_TIME_NS = 2000;
   localparam int CONV_CYCLES = (CONV_TIME_NS + CLOCK_NS - 1) / CLOCK_NS;
   typedef enum logic [1:0] {
      conv_idle_t,
      conv_busy_t,
      conv_done_t
   } conv_state_t;
endpackage

/* File: rtl/fraction_latch.sv */
// Holding register for one fraction byte, frozen on its integer read.
`timescale 1ns/1ps
module fraction_latch #(
   parameter int WIDTH = 5
) (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic [WIDTH-1:0] i_live,
   input wire logic i_freeze,
   input wire logic i_release,
   output logic [7:0] o_byte
);
   logic locked_q;
   logic [WIDTH-1:0] held_q;

   // A new integer read always reloads, even if an earlier one is still held
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         locked_q <= 1'b0;
         held_q <= '0;
      end else if (i_freeze) begin
         locked_q <= 1'b1;
         held_q <= i_live;
      end else if (i_release) begin
         locked_q <= 1'b0;
      end else if (!locked_q) begin
         held_q <= i_live;
      end
   end

   // Unused low bits are zero
   always_comb begin
      o_byte = {held_q, {(8 - WIDTH){1'b0}}};
   end
endmodule // fraction_latch

/* File: verification/thermal_map_sva.sv */
// Port-level concurrent checks for the sensor register bank.
`timescale 1ns/1ps
module thermal_map_sva #(
   parameter int CONV_LEN = 4
) (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_command_valid,
   input wire logic [7:0] i_register_index_bits,
   input wire logic i_write_valid,
   input wire logic [7:0] i_write_data,
   input wire logic i_read_request,
   input wire logic o_read_valid,
   input wire logic [7:0] o_read_data,
   input wire logic o_conversion_start,
   input wire logic [4:0] o_general_config,
   input wire logic [4:0] o_diode_config,
   input wire logic [1:0] o_conversion_rate,
   input wire logic [10:0] o_remote_offset
);
   logic [7:0] idx_q;
   logic [7:0] gap_q;
   logic ro_w;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_reset);
   // Shadow index; a command only steers later cycles
   always_ff @(posedge i_clock) begin
      if (i_reset) idx_q <= 8'h00;
      else if (i_command_valid) idx_q <= i_register_index_bits;
   end
   // Cycles since last start, saturating so long idle never wraps
   always_ff @(posedge i_clock) begin
      if (i_reset || o_conversion_start) gap_q <= 8'h00;
      else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
   end
   assign ro_w = i_write_valid && (idx_q inside {8'h00, 8'h01, 8'h02, 8'h10, 8'h30, 8'h31, 8'h32, 8'h33});
   property p_read_answer; i_read_request |=> o_read_valid; endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered");
   property p_reset_vals; $fell(i_reset) |-> o_general_config == 5'h00 && o_diode_config == 5'h1f
      && o_conversion_rate == 2'h2 && o_remote_offset == 11'h000; endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
   property p_cfg_wr; i_write_valid && idx_q inside {8'h03, 8'h09}
      |=> o_general_config == $past(i_write_data[4:0]); endproperty
   a_cfg_wr: assert property (p_cfg_wr) else $error("config write lost");
   property p_rate_wr; i_write_valid && idx_q inside {8'h04, 8'h0a}
      |=> o_conversion_rate == $past(i_write_data[1:0]); endproperty
   a_rate_wr: assert property (p_rate_wr) else $error("rate write lost");
   property p_diode_wr; i_write_valid && idx_q == 8'hbf |=> o_diode_config == $past(i_write_data[4:0]); endproperty
   a_diode_wr: assert property (p_diode_wr) else $error("diode write lost");
   property p_ro_wr; ro_w
      |=> $stable({o_general_config, o_diode_config, o_conversion_rate, o_remote_offset}); endproperty
   a_ro_wr: assert property (p_ro_wr) else $error("read-only write changed state");
   property p_one_shot; i_write_valid && idx_q == 8'h0f && o_general_config[4] && int'(gap_q) > CONV_LEN + 4
      |=> o_conversion_start ##1 !o_conversion_start; endproperty
   a_one_shot: assert property (p_one_shot) else $error("one-shot start wrong");
   property p_shot_read; i_read_request && idx_q == 8'h0f |=> o_read_data == 8'h00; endproperty
   a_shot_read: assert property (p_shot_read) else $error("one-shot read not zero");
   property p_frac_zero; i_read_request && idx_q == 8'h30 |=> o_read_data[4:0] == 5'h00; endproperty
   a_frac_zero: assert property (p_frac_zero) else $error("unused fraction bits set");
endmodule // thermal_map_sva

/* File: verification/smbus_host_model.sv */
// Host model issuing command, write and read requests to the bank.
`timescale 1ns/1ps
module smbus_host_model (
   input wire logic i_clock,
   input wire logic i_read_valid,
   input wire logic [7:0] i_read_data,
   output logic o_command_valid,
   output logic [7:0] o_index,
   output logic o_write_valid,
   output logic [7:0] o_write_data,
   output logic o_read_request
);
   // Idle request lines at time zero
   initial begin
      o_command_valid = 1'b0;
      o_index = 8'h00;
      o_write_valid = 1'b0;
      o_write_data = 8'h00;
      o_read_request = 1'b0;
   end
   // Random gap so both prompt and slow hosts are exercised
   task automatic pause();
      repeat ($urandom_range(2, 0)) @(posedge i_clock);
   endtask
   // Command byte leads every write; released lines show the inverse, not stale data
   task automatic send_cmd(input logic [7:0] idx);
      pause();
      @(posedge i_clock);
      o_command_valid <= 1'b1;
      o_index <= idx;
      @(posedge i_clock);
      o_command_valid <= 1'b0;
      o_index <= ~idx;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      send_cmd(idx);
      o_write_valid <= 1'b1;
      o_write_data <= d;
      @(posedge i_clock);
      o_write_valid <= 1'b0;
      o_write_data <= ~d;
   endtask
   // Read with or without a fresh command; answer sampled under a bounded wait
   task automatic rd(input logic [7:0] idx, input logic cmd, output logic [7:0] d, output logic ok);
      if (cmd) send_cmd(idx);
      else @(posedge i_clock);
      o_read_request <= 1'b1;
      @(posedge i_clock);
      o_read_request <= 1'b0;
      ok = 1'b0;
      d = 8'h00;
      for (int n = 0; n < 4 && !ok; n++) begin
         #1;
         ok = i_read_valid;
         d = i_read_data;
         if (!ok) @(posedge i_clock);
      end
   endtask
endmodule // smbus_host_model

/* File: verification/thermal_sensor_register_map_tb_top.sv */
// Self-checking bench for the sensor register bank.
`timescale 1ns/1ps
module thermal_sensor_register_map_tb_top;
   localparam int CONV_LEN = 4;
   logic i_clock = 1'b0;
   logic i_reset = 1'b1;
   logic cmd_v, wr_v, rd_q, rd_v, start, crit_n, ovt_n, ok;
   logic flt = 1'b0;
   logic nrdy = 1'b0;
   logic [7:0] idx, wd, rdata, got, old;
   logic [10:0] lt = 11'h0c8;
   logic [12:0] st = 13'h0320;
   logic [12:0] ut = 13'h0320;
   int err_total = 0;
   int n_compared = 0;
   int starts = 0;
   logic [7:0] rst_i [13] = '{8'h03, 8'h09, 8'h04, 8'h0a, 8'h07, 8'h0d, 8'h19,
      8'h20, 8'h21, 8'hbf, 8'h11, 8'h12, 8'h0f};
   logic [7:0] rst_v [13] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h55, 8'h55, 8'h6e,
      8'h55, 8'h0a, 8'h1f, 8'h00, 8'h00, 8'h00};
   logic [7:0] w_i [9] = '{8'h03, 8'h0a, 8'h07, 8'h19, 8'h20, 8'h21, 8'hbf, 8'h11, 8'h12};
   logic [7:0] r_i [9] = '{8'h09, 8'h04, 8'h0d, 8'h19, 8'h20, 8'h21, 8'hbf, 8'h11, 8'h12};
   logic [7:0] msk [9] = '{8'h1f, 8'h03, 8'hff, 8'hff, 8'h7f, 8'h1f, 8'h1f, 8'hff, 8'he0};
   logic [7:0] ro [9] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h30, 8'h31, 8'h32, 8'h33, 8'h55};
   logic [7:0] cf_i [6] = '{8'h03, 8'hbf, 8'h07, 8'h19, 8'h20, 8'h21};
   logic [7:0] cf_d [6] = '{8'h10, 8'h1f, 8'hff, 8'hff, 8'h1e, 8'h05};
   logic [7:0] tr [6] = '{8'h00, 8'h30, 8'h01, 8'h10, 8'h31, 8'h32};
   logic [7:0] shadow [9];
   initial begin
      forever #10 i_clock = ~i_clock;
   end
   thermal_sensor_register_map #(.CONV_LEN(CONV_LEN)) u_dut (.i_clock(i_clock), .i_reset(i_reset),
      .i_command_valid(cmd_v), .i_register_index_bits(idx), .i_write_valid(wr_v), .i_write_data(wd),
      .i_read_request(rd_q), .o_read_valid(rd_v), .o_read_data(rdata), .i_local_temp(lt),
      .i_remote_temp_signed(st), .i_remote_temp_unsigned(ut), .i_diode_fault(flt), .i_not_ready(nrdy),
      .o_conversion_start(start), .o_critical_alarm_n(crit_n), .o_overtemp_alarm_n(ovt_n),
      .o_general_config(), .o_diode_config(), .o_conversion_rate(), .o_remote_offset());
   smbus_host_model u_host (.i_clock(i_clock), .i_read_valid(rd_v), .i_read_data(rdata), .o_command_valid(cmd_v),
      .o_index(idx), .o_write_valid(wr_v), .o_write_data(wd), .o_read_request(rd_q));
   // Start pulses are counted so a doubled or missing conversion shows
   always @(posedge i_clock) if (start) starts <= starts + 1;
   task automatic close_out();
      if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // A read that never answers ends the run at once
   task automatic rchk(input logic [7:0] a, input logic c, input logic [7:0] e, input logic [7:0] m);
      u_host.rd(a, c, got, ok);
      if (!ok) begin
         err_total++;
         close_out();
      end
      else chk(got & m, e & m);
   endtask
   // Expected reading bytes, fractions left justified with unused bits zero
   function automatic logic [7:0] temp_byte(input logic [7:0] a);
      case (a)
         8'h00: return lt[10:3];
         8'h30: return {lt[2:0], 5'h00};
         8'h01: return st[12:5];
         8'h10: return {st[4:0], 3'h0};
         8'h31: return ut[12:5];
         default: return {ut[4:0], 3'h0};
      endcase
   endfunction
   // New live readings, one single conversion, then exactly one start expected
   task automatic conv(input logic [10:0] l, input logic [12:0] s, input logic [12:0] u);
      int s0;
      @(posedge i_clock);
      lt <= l;
      st <= s;
      ut <= u;
      s0 = starts;
      u_host.wr(8'h0f, 8'($urandom));
      repeat (12) @(posedge i_clock);
      #1;
      chk(8'(starts - s0), 8'h01);
   endtask
   // Main sequence
   initial begin
      void'($urandom(32'hd63cee71));
      repeat (10) @(posedge i_clock);
      i_reset <= 1'b0;
      repeat (12) @(posedge i_clock);
      rchk(8'h00, 1'b0, temp_byte(8'h00), 8'hff);
      foreach (rst_i[k]) rchk(rst_i[k], 1'b1, rst_v[k], 8'hff);
      for (int r = 0; r < 3; r++) begin
         foreach (w_i[k]) begin
            shadow[k] = (r == 0) ? 8'hff : (r == 1) ? 8'h00 : 8'($urandom);
            u_host.wr(w_i[k], shadow[k]);
            rchk(r_i[k], 1'b1, shadow[k], msk[k]);
         end
      end
      foreach (ro[k]) u_host.wr(ro[k], 8'($urandom));
      foreach (w_i[k]) rchk(w_i[k], 1'b1, shadow[k], msk[k]);
      rchk(8'h55, 1'b1, 8'h00, 8'hff);
      foreach (cf_i[k]) u_host.wr(cf_i[k], cf_d[k]);
      conv(11'($urandom), 13'($urandom), 13'($urandom));
      foreach (tr[k]) rchk(tr[k], 1'b1, temp_byte(tr[k]), 8'hff);
      rchk(8'h31, 1'b1, temp_byte(8'h31), 8'hff);
      old = temp_byte(8'h32);
      conv(11'($urandom), 13'($urandom), 13'($urandom));
      rchk(8'h32, 1'b1, old, 8'hff);
      rchk(8'h32, 1'b1, temp_byte(8'h32), 8'hff);
      rchk(8'h02, 1'b1, 8'h00, 8'hf0);
      // Fault and not-ready inputs must reach the status bytes
      @(posedge i_clock);
      flt <= 1'b1;
      nrdy <= 1'b1;
      conv(lt, st, ut);
      rchk(8'h02, 1'b1, 8'h02, 8'hf2);
      rchk(8'h33, 1'b1, 8'h02, 8'hff);
      @(posedge i_clock);
      flt <= 1'b0;
      nrdy <= 1'b0;
      conv({8'd40, 3'h0}, 13'h0140, 13'h0140);
      chk({6'h00, crit_n, ovt_n}, 8'h00);
      conv({8'd27, 3'h0}, 13'h0140, 13'h0140);
      chk({6'h00, crit_n, ovt_n}, 8'h00);
      conv({8'd20, 3'h0}, 13'h0140, 13'h0140);
      chk({6'h00, crit_n, ovt_n}, 8'h03);
      close_out();
   end
endmodule // thermal_sensor_register_map_tb_top
bind thermal_sensor_register_map thermal_map_sva #(.CONV_LEN(CONV_LEN)) u_sva (.i_clock(i_clock), .i_reset(i_reset),
   .i_command_valid(i_command_valid), .i_register_index_bits(i_register_index_bits), .i_write_valid(i_write_valid),
   .i_write_data(i_write_data), .i_read_request(i_read_request), .o_read_valid(o_read_valid),
   .o_read_data(o_read_data), .o_conversion_start(o_conversion_start), .o_general_config(o_general_config),
   .o_diode_config(o_diode_config), .o_conversion_rate(o_conversion_rate), .o_remote_offset(o_remote_offset));
